// ==== rtl/csau_addr_gen.v ====
// Effective address generator for the coprocessor store
`default_nettype none

module csau_addr_gen (
  // Base selection
  input wire [31:0] base_val_i,
  input wire [31:0] pc_val_i,
  input wire [3:0] base_sel_i,
  input wire base_absent_i,
  // Offset and indexing
  input wire [7:0] offset_i,
  input wire up_i,
  input wire pre_i,
  // Results
  output wire [31:0] xfer_addr_o,
  output wire [31:0] final_addr_o
);

`include "csau_defs.vh"

  wire use_pc;
  wire [31:0] base_eff;
  wire [31:0] byte_ofs;
  wire [31:0] indexed;

  // No base register means program counter relative
  assign use_pc = base_absent_i | (base_sel_i == `CSAU_PC_REG);
  // Status and mode bits would corrupt the address
  assign base_eff = use_pc ? (pc_val_i & `CSAU_PC_ADDR_MASK) : base_val_i;
  // Word count to bytes; 8-bit magnitude reaches 1020 of the 1023 span
  assign byte_ofs = {22'h00000, offset_i, 2'h0};
  assign indexed = up_i ? (base_eff + byte_ofs) : (base_eff - byte_ofs);
  // Pre-index stores at the indexed address, post-index at the base
  assign xfer_addr_o = pre_i ? indexed : base_eff;
  assign final_addr_o = indexed;

endmodule // csau_addr_gen

`default_nettype wire

// ==== rtl/csau_defs.vh ====
// Constants of the coprocessor store address unit: field positions, offsets, counts
`ifndef CSAU_DEFS_VH
`define CSAU_DEFS_VH

// --------------------------------------------------------------------
// Instruction field positions
// --------------------------------------------------------------------
`define CSAU_COND_HI 31
`define CSAU_COND_LO 28
`define CSAU_CLASS_HI 27
`define CSAU_CLASS_LO 25
`define CSAU_CLASS_VAL 3'h6
`define CSAU_PRE_BIT 24
`define CSAU_UP_BIT 23
`define CSAU_LONG_BIT 22
`define CSAU_WB_BIT 21
`define CSAU_LOAD_BIT 20
`define CSAU_BASE_HI 19
`define CSAU_BASE_LO 16
`define CSAU_CREG_HI 15
`define CSAU_CREG_LO 12
`define CSAU_CNUM_HI 11
`define CSAU_CNUM_LO 8
`define CSAU_OFS_HI 7
`define CSAU_OFS_LO 0
`define CSAU_PC_REG 4'hF

// --------------------------------------------------------------------
// Program counter address bits, status and mode bits stripped
// --------------------------------------------------------------------
`define CSAU_PC_ADDR_MASK 32'h03FFFFFC

// --------------------------------------------------------------------
// Register map and fields
// --------------------------------------------------------------------
`define CSAU_REG_CTRL 4'h0
`define CSAU_REG_STATUS 4'h4
`define CSAU_REG_ADDR 4'h8
`define CSAU_REG_COUNT 4'hC
`define CSAU_CTRL_RST 2'h1
`define CSAU_CTRL_EN_BIT 0
`define CSAU_CTRL_NOTRANS_BIT 1

// --------------------------------------------------------------------
// Timing: cycles a coprocessor is given to accept the instruction
// --------------------------------------------------------------------
`define CSAU_ACCEPT_TIME_NS 80
`define CSAU_CLK_PERIOD_NS 10
`define CSAU_ACCEPT_CYCLES (`CSAU_ACCEPT_TIME_NS / `CSAU_CLK_PERIOD_NS)

`endif

// ==== rtl/csau_store_unit.v ====
// Coprocessor store instruction: condition, handshake, address, write and write-back
// What this block does
// - Coprocessor register contents are written to memory at the effective address.
// - Address indexes a base register, pre-indexed or post-indexed.
// - Long/short bit is passed to the coprocessor; one means long.
// - Translation form drives the active-low translate output low during the write.
// - Four-bit number selects the coprocessor; only the matching one joins in.
// - With write-back and a base register other than the program counter, the new address returns to the base.
// - Offsets reach from minus to plus 1020 bytes around the base.
// - Offset is a word count, shifted left two before use.
// - Eight-bit magnitude is added when up, subtracted otherwise.
// - Status and mode bits are stripped from the program counter base.
// - Without a base register the program counter is the base.
// - A condition code is tested against the status flags.
// - A failed condition performs no transfer and changes nothing but the skip note.
`default_nettype none

`include "csau_defs.vh"

module csau_store_unit #(
  parameter ACCEPT_CYCLES = `CSAU_ACCEPT_CYCLES
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Instruction issue
  input wire instr_valid_i,
  input wire [31:0] instr_i,
  input wire base_absent_i,
  input wire [31:0] base_val_i,
  input wire [31:0] pc_val_i,
  input wire [3:0] flags_i,
  output reg instr_ready_o,
  output reg done_o,
  output reg undef_o,
  // Coprocessor side
  output reg cop_req_o,
  output reg [3:0] cop_num_o,
  output reg [3:0] cop_reg_o,
  output reg cop_long_o,
  input wire cop_accept_i,
  input wire [3:0] cop_id_i,
  input wire cop_data_valid_i,
  input wire [31:0] cop_data_i,
  // Memory bus
  output reg mem_we_o,
  output reg [31:0] mem_addr_o,
  output reg [31:0] mem_wdata_o,
  output reg mem_trans_n_o,
  input wire mem_ack_i,
  // Base register write-back
  output reg wb_en_o,
  output reg [3:0] wb_reg_o,
  output reg [31:0] wb_data_o,
  // Register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o
);

  // ------------------------------------------------------------------
  // States
  // ------------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_HAND = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_MEM = 3'h3;
  localparam ST_WB = 3'h4;
  localparam ST_DONE = 3'h5;
  // Last wait count before the trap
  localparam [31:0] ACC_LAST = ACCEPT_CYCLES - 1;

  reg [2:0] state_r;
  reg [31:0] instr_r;
  reg base_absent_r;
  reg [31:0] base_r;
  reg [31:0] pc_r;
  reg [7:0] wait_r;
  reg [1:0] ctrl_r;
  reg last_undef_r;
  reg last_skip_r;
  reg [31:0] last_addr_r;
  reg [31:0] count_r;

  wire [3:0] cond;
  wire flag_n;
  wire flag_z;
  wire flag_c;
  wire flag_v;
  reg cond_pass;
  wire is_store;
  wire pre_bit;
  wire wb_bit;
  wire do_trans;
  wire do_wb;
  wire [31:0] xfer_addr;
  wire [31:0] final_addr;

  // ------------------------------------------------------------------
  // Condition test on the flags at issue
  // ------------------------------------------------------------------
  assign cond = instr_i[`CSAU_COND_HI:`CSAU_COND_LO];
  assign flag_n = flags_i[3];
  assign flag_z = flags_i[2];
  assign flag_c = flags_i[1];
  assign flag_v = flags_i[0];

  always @* begin
    case (cond)
      4'h0: cond_pass = flag_z;
      4'h1: cond_pass = ~flag_z;
      4'h2: cond_pass = flag_c;
      4'h3: cond_pass = ~flag_c;
      4'h4: cond_pass = flag_n;
      4'h5: cond_pass = ~flag_n;
      4'h6: cond_pass = flag_v;
      4'h7: cond_pass = ~flag_v;
      4'h8: cond_pass = flag_c & ~flag_z;
      4'h9: cond_pass = ~flag_c | flag_z;
      4'hA: cond_pass = (flag_n == flag_v);
      4'hB: cond_pass = (flag_n != flag_v);
      4'hC: cond_pass = ~flag_z & (flag_n == flag_v);
      4'hD: cond_pass = flag_z | (flag_n != flag_v);
      4'hE: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  end

  // Only the store form of the coprocessor transfer class is handled here
  assign is_store = (instr_i[`CSAU_CLASS_HI:`CSAU_CLASS_LO] == `CSAU_CLASS_VAL) &
                    ~instr_i[`CSAU_LOAD_BIT];

  // ------------------------------------------------------------------
  // Address generation on the captured instruction
  // ------------------------------------------------------------------
  assign pre_bit = instr_r[`CSAU_PRE_BIT];
  assign wb_bit = instr_r[`CSAU_WB_BIT];
  // The translation form is post-indexed with the write-back bit set
  assign do_trans = ~pre_bit & wb_bit & ~ctrl_r[`CSAU_CTRL_NOTRANS_BIT];
  // Post-index always moves a present base other than the program counter; pre-index only when asked
  assign do_wb = (wb_bit | ~pre_bit) & ~base_absent_r &
                 (instr_r[`CSAU_BASE_HI:`CSAU_BASE_LO] != `CSAU_PC_REG);

  csau_addr_gen u_addr (
    .base_val_i(base_r),
    .pc_val_i(pc_r),
    .base_sel_i(instr_r[`CSAU_BASE_HI:`CSAU_BASE_LO]),
    .base_absent_i(base_absent_r),
    .offset_i(instr_r[`CSAU_OFS_HI:`CSAU_OFS_LO]),
    .up_i(instr_r[`CSAU_UP_BIT]),
    .pre_i(pre_bit),
    .xfer_addr_o(xfer_addr),
    .final_addr_o(final_addr)
  );

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      instr_r <= 32'h00000000;
      base_absent_r <= 1'b0;
      base_r <= 32'h00000000;
      pc_r <= 32'h00000000;
      wait_r <= 8'h00;
      instr_ready_o <= 1'b0;
      done_o <= 1'b0;
      undef_o <= 1'b0;
      cop_req_o <= 1'b0;
      cop_num_o <= 4'h0;
      cop_reg_o <= 4'h0;
      cop_long_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
      mem_wdata_o <= 32'h00000000;
      mem_trans_n_o <= 1'b1;
      wb_en_o <= 1'b0;
      wb_reg_o <= 4'h0;
      wb_data_o <= 32'h00000000;
      last_undef_r <= 1'b0;
      last_skip_r <= 1'b0;
      last_addr_r <= 32'h00000000;
      count_r <= 32'h00000000;
    end else begin
      done_o <= 1'b0;
      undef_o <= 1'b0;
      wb_en_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          instr_ready_o <= ctrl_r[`CSAU_CTRL_EN_BIT];
          if (instr_valid_i && instr_ready_o && is_store) begin
            instr_ready_o <= 1'b0;
            instr_r <= instr_i;
            base_absent_r <= base_absent_i;
            base_r <= base_val_i;
            pc_r <= pc_val_i;
            if (cond_pass) begin
              // Number, register and length go out with the request
              cop_req_o <= 1'b1;
              cop_num_o <= instr_i[`CSAU_CNUM_HI:`CSAU_CNUM_LO];
              cop_reg_o <= instr_i[`CSAU_CREG_HI:`CSAU_CREG_LO];
              cop_long_o <= instr_i[`CSAU_LONG_BIT];
              wait_r <= 8'h00;
              state_r <= ST_HAND;
            end else begin
              // Skipped: no transfer, no write-back, no state but the note
              last_skip_r <= 1'b1;
              state_r <= ST_DONE;
            end
          end
        end
        ST_HAND: begin
          // Accept counts only from the coprocessor whose number matches
          if (cop_accept_i && (cop_id_i == cop_num_o)) begin
            cop_req_o <= 1'b0;
            state_r <= ST_DATA;
          end else if ({24'h000000, wait_r} == ACC_LAST) begin
            // Nobody answered: trap instead of storing
            cop_req_o <= 1'b0;
            undef_o <= 1'b1;
            last_undef_r <= 1'b1;
            last_skip_r <= 1'b0;
            state_r <= ST_DONE;
          end else begin
            wait_r <= wait_r + 8'h01;
          end
        end
        ST_DATA: begin
          if (cop_data_valid_i) begin
            mem_we_o <= 1'b1;
            mem_addr_o <= xfer_addr;
            mem_wdata_o <= cop_data_i;
            mem_trans_n_o <= ~do_trans;
            state_r <= ST_MEM;
          end
        end
        ST_MEM: begin
          // Write and translate request stand until the memory takes them
          if (mem_ack_i) begin
            mem_we_o <= 1'b0;
            mem_trans_n_o <= 1'b1;
            last_addr_r <= mem_addr_o;
            count_r <= count_r + 32'h00000001;
            last_undef_r <= 1'b0;
            last_skip_r <= 1'b0;
            state_r <= ST_WB;
          end
        end
        ST_WB: begin
          if (do_wb) begin
            wb_en_o <= 1'b1;
            wb_reg_o <= instr_r[`CSAU_BASE_HI:`CSAU_BASE_LO];
            wb_data_o <= final_addr;
          end
          state_r <= ST_DONE;
        end
        ST_DONE: begin
          // Flags are never an output of this unit, so they stay as they were
          done_o <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Register port: control, status, last address, store count
  // ------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_r <= `CSAU_CTRL_RST;
      reg_rdata_o <= 32'h00000000;
    end else begin
      if (reg_wr_i && (reg_addr_i == `CSAU_REG_CTRL)) begin
        ctrl_r <= reg_wdata_i[1:0];
      end
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `CSAU_REG_CTRL: reg_rdata_o <= {30'h0000000, ctrl_r};
          `CSAU_REG_STATUS: reg_rdata_o <= {29'h0000000, last_skip_r, last_undef_r,
                                            (state_r != ST_IDLE)};
          `CSAU_REG_ADDR: reg_rdata_o <= last_addr_r;
          `CSAU_REG_COUNT: reg_rdata_o <= count_r;
          default: reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // csau_store_unit

`default_nettype wire

// ==== sim/csau_cop_model.sv ====
// Coprocessor and memory model on the far side of the store unit
`default_nettype none

module csau_cop_model (
  // Clock and bench settings
  input wire logic clk_i,
  input wire logic [3:0] my_id_i,
  input wire logic slow_i,
  // Coprocessor side
  input wire logic cop_req_i,
  input wire logic [3:0] cop_num_i,
  input wire logic [3:0] cop_reg_i,
  output logic cop_accept_o,
  output logic [3:0] cop_id_o,
  output logic cop_data_valid_o,
  output logic [31:0] cop_data_o,
  // Memory
  input wire logic mem_we_i,
  output logic mem_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_r = 1'b0;
  logic [1:0] cnt_r = 2'h0;
  initial begin
    cop_accept_o = 1'b0;
    cop_data_valid_o = 1'b0;
    cop_data_o = 32'h0;
    mem_ack_o = 1'b0;
  end
  assign cop_id_o = my_id_i;
  always @(posedge clk_i) begin
    cop_accept_o <= 1'b0;
    mem_ack_o <= 1'b0;
    if (cop_req_i && cop_num_i == my_id_i && !cop_accept_o && !ph_r) begin
      cop_accept_o <= 1'b1;
      ph_r <= 1'b1;
    end
    if (cop_accept_o) begin
      cop_data_valid_o <= 1'b1;
      cop_data_o <= {28'hA5A5000, cop_reg_i};
    end else if (mem_we_i || !ph_r) begin
      // Released data toggles so stale values cannot pass
      cop_data_valid_o <= 1'b0;
      cop_data_o <= ~cop_data_o;
    end
    if (mem_we_i && !mem_ack_o) begin
      cnt_r <= cnt_r + 2'h1;
      if (!slow_i || cnt_r == 2'h2) begin
        mem_ack_o <= 1'b1;
        cnt_r <= 2'h0;
        ph_r <= 1'b0;
      end
    end
  end
endmodule // csau_cop_model
`default_nettype wire

// ==== sim/csau_store_unit_monitor.sv ====
// Port checker for the coprocessor store unit
`default_nettype none

module csau_store_unit_monitor #(
  parameter ACCEPT_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Instruction issue
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic done_o,
  input wire logic undef_o,
  // Coprocessor side
  input wire logic cop_req_o,
  input wire logic [3:0] cop_num_o,
  input wire logic [3:0] cop_reg_o,
  input wire logic cop_long_o,
  input wire logic cop_accept_i,
  input wire logic [3:0] cop_id_i,
  // Memory and write-back
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_trans_n_o,
  input wire logic mem_ack_i,
  input wire logic wb_en_o,
  input wire logic [3:0] wb_reg_o,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Margin of two cycles over the hand-shake timeout
  localparam int RQW = ACCEPT_CYCLES + 2;
  wire tk = instr_valid_i & instr_ready_o & (instr_i[27:25] == 3'h6) & ~instr_i[20];
  wire hit = cop_accept_i & (cop_id_i == cop_num_o);
  logic [31:0] lat_r;
  always @(posedge clk_i) if (tk) lat_r <= instr_i;
  // Suppress-translate bit of the control register, tracked from the port
  logic nt_r;
  always @(posedge clk_i) begin
    if (!nrst_i) nt_r <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 4'h0) nt_r <= reg_wdata_i[1];
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  num_sel_a: assert property (
    tk && instr_i[31:28] == 4'hE |=> cop_req_o && cop_num_o == lat_r[11:8]
    && cop_reg_o == lat_r[15:12] && cop_long_o == lat_r[22])
    else $error("coprocessor request fields wrong");
  cond_skip_a: assert property (
    tk && instr_i[31:28] == 4'hF |=> !cop_req_o ##1 done_o && !mem_we_o)
    else $error("failed condition not skipped");
  req_end_a: assert property (hit && cop_req_o |=> !cop_req_o)
    else $error("request kept after accept");
  req_bound_a: assert property ($rose(cop_req_o) |-> ##[1:RQW] !cop_req_o)
    else $error("request never times out");
  undef_done_a: assert property (undef_o |-> !mem_we_o ##1 done_o && !undef_o)
    else $error("undefined without done");
  we_hold_a: assert property (mem_we_o && !mem_ack_i |=> mem_we_o && $stable(mem_addr_o))
    else $error("write dropped before ack");
  trans_pin_a: assert property (
    mem_we_o |-> mem_trans_n_o == (nt_r || !(!lat_r[24] && lat_r[21])))
    else $error("translate level wrong");
  wb_reg_a: assert property (
    wb_en_o |-> wb_reg_o == lat_r[19:16] && lat_r[19:16] != 4'hF ##1 done_o)
    else $error("write-back register wrong");

  cover property (undef_o);
  cover property (wb_en_o);
  cover property (mem_we_o && mem_ack_i && !mem_trans_n_o);
endmodule // csau_store_unit_monitor
`default_nettype wire

// ==== sim/csau_store_unit_tb.sv ====
// Self-checking bench for the coprocessor store unit
`default_nettype none

module csau_store_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic instr_valid_i = 1'b0, base_absent_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [31:0] instr_i = 32'h0, base_val_i = 32'h0, pc_val_i = 32'h0, reg_wdata_i = 32'h0;
  logic [3:0] flags_i = 4'h0, reg_addr_i = 4'h0, my_id = 4'h0;
  logic slow = 1'b0, wt, lu = 1'b0, ls, nt = 1'b0;
  wire instr_ready_o, done_o, undef_o, cop_req_o, cop_long_o, cop_accept_i, cop_data_valid_i;
  wire mem_we_o, mem_trans_n_o, mem_ack_i, wb_en_o;
  wire [3:0] cop_num_o, cop_reg_o, cop_id_i, wb_reg_o;
  wire [31:0] cop_data_i, mem_addr_o, mem_wdata_o, wb_data_o, reg_rdata_o;
  int err_count = 0, compares = 0, nw = 0, nwb = 0, nu = 0, np = 0;
  logic [31:0] wa, wd, wbd, lastx;
  integer seed = 32'hBF99;

  always #5 clk_i = ~clk_i;

  csau_store_unit #(.ACCEPT_CYCLES(2)) i_csau_store_unit (.clk_i(clk_i), .nrst_i(nrst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .base_absent_i(base_absent_i),
    .base_val_i(base_val_i), .pc_val_i(pc_val_i), .flags_i(flags_i),
    .instr_ready_o(instr_ready_o), .done_o(done_o), .undef_o(undef_o), .cop_req_o(cop_req_o),
    .cop_num_o(cop_num_o), .cop_reg_o(cop_reg_o), .cop_long_o(cop_long_o),
    .cop_accept_i(cop_accept_i), .cop_id_i(cop_id_i), .cop_data_valid_i(cop_data_valid_i),
    .cop_data_i(cop_data_i), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_trans_n_o(mem_trans_n_o), .mem_ack_i(mem_ack_i),
    .wb_en_o(wb_en_o), .wb_reg_o(wb_reg_o), .wb_data_o(wb_data_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
  csau_cop_model i_csau_cop_model (.clk_i(clk_i), .my_id_i(my_id), .slow_i(slow),
    .cop_req_i(cop_req_o), .cop_num_i(cop_num_o), .cop_reg_i(cop_reg_o),
    .cop_accept_o(cop_accept_i), .cop_id_o(cop_id_i), .cop_data_valid_o(cop_data_valid_i),
    .cop_data_o(cop_data_i), .mem_we_i(mem_we_o), .mem_ack_o(mem_ack_i));

  always @(posedge clk_i) begin
    if (mem_we_o === 1'b1 && mem_ack_i === 1'b1) begin
      wa <= mem_addr_o;
      wd <= mem_wdata_o;
      wt <= mem_trans_n_o;
      nw <= nw + 1;
    end
    if (wb_en_o === 1'b1) begin
      wbd <= wb_data_o;
      nwb <= nwb + 1;
    end
    if (undef_o === 1'b1) nu <= nu + 1;
  end

  // ------------------------------------------------------------
  // Tasks and expectation functions
  // ------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %0t seen %h want %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // Flags are {N,Z,C,V}; odd codes invert the even test
  function logic cpass(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = ~f[2] & (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    cpass = (c == 4'hF) ? 1'b0 : r ^ c[0];
  endfunction
  task st(input logic [31:0] ins, bv, pv, input logic ab, input logic [3:0] fl);
    logic [31:0] bs, ea, xa;
    logic ok, wbx, go;
    int n0, b0, u0, k;
    bs = (ab || ins[19:16] == 4'hF) ? (pv & 32'h03FFFFFC) : bv;
    ea = ins[23] ? bs + {ins[7:0], 2'b00} : bs - {ins[7:0], 2'b00};
    xa = ins[24] ? ea : bs;
    ok = cpass(ins[31:28], fl);
    go = ok && my_id == ins[11:8];
    wbx = go && (ins[21] || !ins[24]) && !ab && ins[19:16] != 4'hF;
    n0 = nw;
    b0 = nwb;
    u0 = nu;
    k = 0;
    while (instr_ready_o !== 1'b1 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= ins;
    base_absent_i <= ab;
    base_val_i <= bv;
    pc_val_i <= pv;
    flags_i <= fl;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (done_o !== 1'b1 && k < 50);
    chk(done_o, 1'b1);
    if (go) begin
      chk(nw - n0, 1);
      chk(wa, xa);
      chk(wd, {28'hA5A5000, ins[15:12]});
      chk(wt, nt || !(!ins[24] && ins[21]));
      lastx = xa;
      np++;
    end else chk(nw - n0, 0);
    chk(nwb - b0, wbx);
    if (wbx) chk(wbd, ea);
    chk(nu - u0, ok && !go);
    // A skipped instruction leaves the last-undefined note alone
    if (ok) lu = !go;
    ls = !ok;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, 32'h1);
    rd(4'h2, 32'h0);
    wr(4'h0, 32'h0);
    // Ready follows the enable one cycle late
    repeat (2) @(negedge clk_i);
    chk(instr_ready_o, 1'b0);
    // Translate form with translation suppressed: the pin stays high
    wr(4'h0, 32'h3);
    nt = 1'b1;
    my_id = 4'h2;
    st(32'hECA15204, 32'h00001000, 32'h00000000, 1'b0, 4'h0);
    nt = 1'b0;
    wr(4'h0, 32'h1);
    for (int i = 0; i < 48; i++) begin
      logic [31:0] ins, r;
      ins = $random(seed);
      r = $random(seed);
      ins[27:25] = 3'h6;
      ins[20] = 1'b0;
      ins[31:28] = i[3:0];
      // Corners: largest offset down and up, then PC as base with the coprocessor number not matching
      if (i < 4) begin
        ins[7:0] = 8'hFF;
        ins[23] = i[0];
      end
      if (i == 3) ins[19:16] = 4'hF;
      my_id = (i % 7 == 3) ? ins[11:8] ^ 4'h1 : ins[11:8];
      slow = i[1];
      st(ins, $random(seed), $random(seed) | 32'hFC000003, i % 8 == 2, r[3:0]);
    end
    rd(4'h8, lastx);
    rd(4'hC, np);
    rd(4'h4, {29'h0, ls, lu, 1'b0});
    print_verdict;
  end
  initial begin
    #60000;
    err_count++;
    print_verdict;
  end
endmodule // csau_store_unit_tb

bind csau_store_unit csau_store_unit_monitor #(.ACCEPT_CYCLES(ACCEPT_CYCLES))
  i_csau_store_unit_monitor (.clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o), .undef_o(undef_o),
  .cop_req_o(cop_req_o), .cop_num_o(cop_num_o), .cop_reg_o(cop_reg_o),
  .cop_long_o(cop_long_o), .cop_accept_i(cop_accept_i), .cop_id_i(cop_id_i),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_trans_n_o(mem_trans_n_o),
  .mem_ack_i(mem_ack_i), .wb_en_o(wb_en_o), .wb_reg_o(wb_reg_o), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i));
`default_nettype wire
